// >>> pkg/cicc_consts.svh
/*
 * Constants of the camera input capture configuration block: register
 * offsets, field positions, reset values, bus and stream encodings.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef CICC_CONSTS_SVH
`define CICC_CONSTS_SVH

// register byte offsets, 4-bit address space
`define CICC_ADDR_CONFIG   4'h0
`define CICC_ADDR_STATUS   4'h4

// capture_config reset value and writable bits
`define CICC_CFG_RESET     32'h0000_0000
`define CICC_CFG_WMASK     32'h0000_7f03

// capture_config field positions
`define CICC_FS_POL_BIT    14
`define CICC_LS_POL_BIT    13
`define CICC_EDGE_BIT      12
`define CICC_BURST_HI      11
`define CICC_BURST_LO      10
`define CICC_PAD_BIT       9
`define CICC_FS_SRC_BIT    8
`define CICC_RSVD_BIT      7
`define CICC_MODE_HI       1
`define CICC_MODE_LO       0

// embedded timing reference sequence
`define CICC_TRS_FF        8'hff
`define CICC_TRS_00        8'h00
`define CICC_XY_V_BIT      5
`define CICC_XY_H_BIT      4

// ahb burst encodings
`define CICC_HBURST_INCR4  3'h3
`define CICC_HBURST_INCR8  3'h5
`define CICC_HBURST_INCR16 3'h7

// axi responses
`define CICC_RESP_OKAY     2'h0
`define CICC_RESP_SLVERR   2'h2

// packer: index of the last received byte in a word
`define CICC_LAST_PADDED   2'h2
`define CICC_LAST_FULL     2'h3
`define CICC_ZERO_BYTE     8'h00

`endif

// >>> pkg/cicc_pkg.sv
/*
 * Types of the camera input capture configuration block.
 * Assumes the constants header sits beside it.
 */
`include "cicc_consts.svh"

package cicc_pkg;

    // sample mode field, in field order
    typedef enum logic [1:0] {
        CICC_MODE_PROG_EMB,
        CICC_MODE_INTERLACE_EMB,
        CICC_MODE_GATED,
        CICC_MODE_RSVD
    } cicc_mode_t;

    // burst type field, in field order
    typedef enum logic [1:0] {
        CICC_BURST_4,
        CICC_BURST_8,
        CICC_BURST_16,
        CICC_BURST_RSVD
    } cicc_burst_t;

    // embedded timing reference decoder
    typedef enum logic [1:0] {
        CICC_TRS_IDLE,
        CICC_TRS_FF_SEEN,
        CICC_TRS_Z1,
        CICC_TRS_Z2
    } cicc_trs_t;

endpackage

// >>> core/cicc_sync.sv
/*
 * Two-flop synchroniser for a bundle of sensor pins.
 * Assumes the pins are asynchronous to aclk; only sync_out is read.
 */
`timescale 1ns/1ns
`default_nettype none

module cicc_sync
    import cicc_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         ce,
    input  wire logic [W-1:0] async_in,
    output var  logic [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    // one pair of flops per pin
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                meta_q[i]   <= 1'b0;
                sync_out[i] <= 1'b0;
            end else if (ce) begin
                meta_q[i]   <= async_in[i];
                sync_out[i] <= meta_q[i];
            end
        end
    end

endmodule // cicc_sync

`default_nettype wire

// >>> core/cicc_packer.sv
/*
 * Packs received bytes into 32-bit words, first byte in the low lane,
 * optionally with a zero top byte after every three bytes.
 * Assumes byte_valid is a one-cycle strobe on aclk.
 */
`timescale 1ns/1ns
`default_nettype none
`include "cicc_consts.svh"

module cicc_packer
    import cicc_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic        clear,
    input  wire logic        zero_pad,
    input  wire logic        byte_valid,
    input  wire logic [7:0]  byte_data,
    output var  logic [31:0] word_data,
    output var  logic        word_valid
);

    logic [1:0]  cnt_q;
    logic [23:0] acc_q;
    logic [1:0]  last;

    // three bytes per word when padding, four otherwise
    assign last = zero_pad ? `CICC_LAST_PADDED : `CICC_LAST_FULL;

    // byte collection and word completion
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q      <= 2'h0;
            acc_q      <= 24'h000000;
            word_data  <= 32'h00000000;
            word_valid <= 1'b0;
        end else if (ce) begin
            word_valid <= 1'b0;
            if (clear) begin
                cnt_q <= 2'h0;
            end else if (byte_valid) begin
                if (cnt_q >= last) begin
                    word_data  <= zero_pad ?
                        {`CICC_ZERO_BYTE, byte_data, acc_q[15:0]} :
                        {byte_data, acc_q};
                    word_valid <= 1'b1;
                    cnt_q      <= 2'h0;
                end else begin
                    acc_q[{cnt_q, 3'h0} +: 8] <= byte_data;
                    cnt_q <= cnt_q + 2'h1;
                end
            end
        end
    end

    property p_zero_pad;
        @(posedge aclk) disable iff (!aresetn)
        (ce && byte_valid && zero_pad && !clear &&
         cnt_q == `CICC_LAST_PADDED)
            |=> (word_valid && word_data[31:24] == `CICC_ZERO_BYTE);
    endproperty
    a_zero_pad: assert property (p_zero_pad)
        else $error("padded word lacks zero top byte");

    property p_no_pad;
        @(posedge aclk) disable iff (!aresetn)
        (ce && byte_valid && !zero_pad && !clear &&
         cnt_q == `CICC_LAST_PADDED)
            |=> !word_valid;
    endproperty
    a_no_pad: assert property (p_no_pad)
        else $error("word closed after three bytes without padding");

endmodule // cicc_packer

`default_nettype wire

// >>> core/cicc_top.sv
/*
 * Camera input capture configuration: AXI4-Lite register slave, sensor
 * pin sampling, sync polarity, embedded sync decode, byte packing and
 * DMA burst selection.
 * Assumes sensor pins are asynchronous and pclk is far below aclk.
 */
// Decided for this implementation: register access over AXI4-Lite and the address map.
// Notes on behaviour
// - line sync polarity bit picks active level
// - edge select bit picks pixel clock edge
// - burst field maps to INCR4, INCR8, INCR16
// - zero pad adds zero byte per three
// - frame source bit only in progressive embedded
// - source 0 uses codes, 1 uses pin
// - frame polarity applies only to pin sync
`timescale 1ns/1ns
`default_nettype none
`include "cicc_consts.svh"

module cicc_top
    import cicc_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic [3:0]  awaddr,
    input  wire logic [2:0]  awprot,
    input  wire logic        awvalid,
    output var  logic        awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output var  logic        wready,
    output var  logic [1:0]  bresp,
    output var  logic        bvalid,
    input  wire logic        bready,
    input  wire logic [3:0]  araddr,
    input  wire logic [2:0]  arprot,
    input  wire logic        arvalid,
    output var  logic        arready,
    output var  logic [31:0] rdata,
    output var  logic [1:0]  rresp,
    output var  logic        rvalid,
    input  wire logic        rready,
    input  wire logic        pclk_pin,
    input  wire logic        line_sync_pin,
    input  wire logic        frame_sync_pin,
    input  wire logic [7:0]  data_pin,
    output var  logic [31:0] pixel_word,
    output var  logic        pixel_word_valid,
    output var  logic        frame_start,
    output var  logic [2:0]  dma_hburst,
    output var  logic        dma_burst_reserved
);
    logic [31:0] cfg_q;
    logic [31:0] status;
    logic [15:0] word_cnt_q;
    logic        aw_take;
    logic        ar_take;
    logic [31:0] strb_mask;
    logic [31:0] wmask;
    logic        s_pclk;
    logic        s_line;
    logic        s_frame;
    logic [7:0]  s_data;
    logic        pclk_prev_q;
    logic        sample_evt;
    logic        ls_active;
    logic        fs_pin_active;
    logic        use_pin_fs;
    logic        frame_active;
    logic        line_active;
    logic        frame_prev_q;
    logic        capture;
    logic        emb_v_q;
    logic        emb_h_q;
    cicc_trs_t   trs_q;
    cicc_mode_t  mode;
    cicc_burst_t burst_sel;

    // register slave handshakes
    assign awready = ce & ~bvalid & wvalid;
    assign wready  = ce & ~bvalid & awvalid;
    assign aw_take = ce & ~bvalid & awvalid & wvalid;
    assign arready = ce & ~rvalid;
    assign ar_take = arready & arvalid;

    // byte lanes limited to writable bits
    assign strb_mask = {{8{wstrb[3]}}, {8{wstrb[2]}},
                        {8{wstrb[1]}}, {8{wstrb[0]}}};
    assign wmask     = strb_mask & `CICC_CFG_WMASK;

    // capture_config storage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_q <= `CICC_CFG_RESET;
        end else if (ce && aw_take &&
                     {awaddr[3:2], 2'h0} == `CICC_ADDR_CONFIG) begin
            cfg_q <= (cfg_q & ~wmask) | (wdata & wmask);
        end
    end

    // write response, held until bready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= `CICC_RESP_OKAY;
        end else if (ce) begin
            if (aw_take) begin
                bvalid <= 1'b1;
                bresp  <= ({awaddr[3:2], 2'h0} == `CICC_ADDR_CONFIG ||
                           {awaddr[3:2], 2'h0} == `CICC_ADDR_STATUS) ?
                          `CICC_RESP_OKAY : `CICC_RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // status word: live capture state
    assign status = {word_cnt_q, 12'h000, dma_burst_reserved,
                     use_pin_fs, line_active, frame_active};
    // read data, held until rready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h00000000;
            rresp  <= `CICC_RESP_OKAY;
        end else if (ce) begin
            if (ar_take) begin
                rvalid <= 1'b1;
                rresp  <= `CICC_RESP_OKAY;
                case ({araddr[3:2], 2'h0})
                    `CICC_ADDR_CONFIG: rdata <= cfg_q;
                    `CICC_ADDR_STATUS: rdata <= status;
                    default: begin
                        rdata <= 32'h00000000;
                        rresp <= `CICC_RESP_SLVERR;
                    end
                endcase
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // sensor pins, two flops each
    cicc_sync #(
        .W (11)
    ) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .ce       (ce),
        .async_in ({data_pin, frame_sync_pin, line_sync_pin, pclk_pin}),
        .sync_out ({s_data, s_frame, s_line, s_pclk})
    );

    assign mode      = cicc_mode_t'(cfg_q[`CICC_MODE_HI:`CICC_MODE_LO]);
    assign burst_sel = cicc_burst_t'(cfg_q[`CICC_BURST_HI:`CICC_BURST_LO]);
    // pixel clock history for edge finding
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pclk_prev_q <= 1'b0;
        end else if (ce) begin
            pclk_prev_q <= s_pclk;
        end
    end

    // selected sampling edge
    assign sample_evt = cfg_q[`CICC_EDGE_BIT] ?
                        (pclk_prev_q & ~s_pclk) :
                        (~pclk_prev_q & s_pclk);

    // polarity: bit set means active low
    assign ls_active     = s_line ^ cfg_q[`CICC_LS_POL_BIT];
    assign fs_pin_active = s_frame ^ cfg_q[`CICC_FS_POL_BIT];

    // source bit counts only in progressive embedded mode
    always_comb begin
        case (mode)
            CICC_MODE_PROG_EMB:      use_pin_fs = cfg_q[`CICC_FS_SRC_BIT];
            CICC_MODE_INTERLACE_EMB: use_pin_fs = 1'b0;
            default:                 use_pin_fs = 1'b1;
        endcase
    end

    // pins or embedded codes frame the active area
    assign frame_active = use_pin_fs ? fs_pin_active : ~emb_v_q;
    assign line_active  = use_pin_fs ? ls_active : ~emb_h_q;

    // timing reference decoder on sampled bytes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trs_q   <= CICC_TRS_IDLE;
            emb_v_q <= 1'b1;
            emb_h_q <= 1'b1;
        end else if (ce && sample_evt) begin
            case (trs_q)
                CICC_TRS_IDLE:
                    if (s_data == `CICC_TRS_FF) trs_q <= CICC_TRS_FF_SEEN;
                CICC_TRS_FF_SEEN:
                    if (s_data == `CICC_TRS_00) trs_q <= CICC_TRS_Z1;
                    else if (s_data != `CICC_TRS_FF) trs_q <= CICC_TRS_IDLE;
                CICC_TRS_Z1:
                    trs_q <= (s_data == `CICC_TRS_00) ?
                             CICC_TRS_Z2 : CICC_TRS_IDLE;
                CICC_TRS_Z2: begin
                    emb_v_q <= s_data[`CICC_XY_V_BIT];
                    emb_h_q <= s_data[`CICC_XY_H_BIT];
                    trs_q   <= CICC_TRS_IDLE;
                end
                default: trs_q <= CICC_TRS_IDLE;
            endcase
        end
    end

    // code bytes never reach the packer while embedded codes frame the data
    assign capture = sample_evt & frame_active & line_active &
                     (use_pin_fs |
                      (trs_q == CICC_TRS_IDLE && s_data != `CICC_TRS_FF));

    // frame start pulse and words per frame
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            frame_prev_q <= 1'b0;
            frame_start  <= 1'b0;
            word_cnt_q   <= 16'h0000;
        end else if (ce) begin
            frame_prev_q <= frame_active;
            frame_start  <= frame_active & ~frame_prev_q;
            if (frame_active & ~frame_prev_q) begin
                word_cnt_q <= 16'h0000;
            end else if (pixel_word_valid) begin
                word_cnt_q <= word_cnt_q + 16'h0001;
            end
        end
    end

    cicc_packer u_packer (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .ce         (ce),
        .clear      (frame_active & ~frame_prev_q),
        .zero_pad   (cfg_q[`CICC_PAD_BIT]),
        .byte_valid (capture),
        .byte_data  (s_data),
        .word_data  (pixel_word),
        .word_valid (pixel_word_valid)
    );

    // dma burst selection, reserved code falls back to INCR4
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dma_hburst         <= `CICC_HBURST_INCR4;
            dma_burst_reserved <= 1'b0;
        end else if (ce) begin
            dma_burst_reserved <= (burst_sel == CICC_BURST_RSVD);
            case (burst_sel)
                CICC_BURST_8:  dma_hburst <= `CICC_HBURST_INCR8;
                CICC_BURST_16: dma_hburst <= `CICC_HBURST_INCR16;
                default:       dma_hburst <= `CICC_HBURST_INCR4;
            endcase
        end
    end

    // rule checks
    property p_line_pol;
        @(posedge aclk) disable iff (!aresetn)
        use_pin_fs |-> (line_active == (cfg_q[`CICC_LS_POL_BIT] ?
                                        !s_line : s_line));
    endproperty
    a_line_pol: assert property (p_line_pol)
        else $error("line sync polarity not honoured");

    property p_edge;
        @(posedge aclk) disable iff (!aresetn)
        (ce && $past(ce) && sample_evt) |->
            (cfg_q[`CICC_EDGE_BIT] ? $fell(s_pclk) : $rose(s_pclk));
    endproperty
    a_edge: assert property (p_edge)
        else $error("sample taken on wrong pixel clock edge");

    property p_burst8;
        @(posedge aclk) disable iff (!aresetn)
        (ce && burst_sel == CICC_BURST_8 ##1 ce)
            |-> dma_hburst == `CICC_HBURST_INCR8;
    endproperty
    a_burst8: assert property (p_burst8)
        else $error("burst code 01 did not give INCR8");

    property p_src_ignored;
        @(posedge aclk) disable iff (!aresetn)
        (mode != CICC_MODE_PROG_EMB)
            |-> (use_pin_fs == (mode != CICC_MODE_INTERLACE_EMB));
    endproperty
    a_src_ignored: assert property (p_src_ignored)
        else $error("source bit acted outside progressive mode");

    property p_src_codes;
        @(posedge aclk) disable iff (!aresetn)
        (mode == CICC_MODE_PROG_EMB && !cfg_q[`CICC_FS_SRC_BIT])
            |-> (frame_active == !emb_v_q);
    endproperty
    a_src_codes: assert property (p_src_codes)
        else $error("frame sync not taken from embedded codes");

    property p_fs_pol;
        @(posedge aclk) disable iff (!aresetn)
        (use_pin_fs && cfg_q[`CICC_FS_POL_BIT]) |-> (frame_active != s_frame);
    endproperty
    a_fs_pol: assert property (p_fs_pol)
        else $error("frame sync polarity not honoured");

    property p_rsvd;
        @(posedge aclk) disable iff (!aresetn)
        (aw_take && wdata[`CICC_RSVD_BIT]) |=> !cfg_q[`CICC_RSVD_BIT];
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bit took a write");

    property p_cov_frame;
        @(posedge aclk) disable iff (!aresetn) frame_start;
    endproperty
    c_cov_frame: cover property (p_cov_frame);
    property p_cov_emb_word;
        @(posedge aclk) disable iff (!aresetn)
        pixel_word_valid && !use_pin_fs;
    endproperty
    c_cov_emb_word: cover property (p_cov_emb_word);
    property p_cov_pad_word;
        @(posedge aclk) disable iff (!aresetn)
        pixel_word_valid && cfg_q[`CICC_PAD_BIT];
    endproperty
    c_cov_pad_word: cover property (p_cov_pad_word);

endmodule // cicc_top

`default_nettype wire

// >>> verification/cicc_sensor_model.sv
/*
 * Image sensor model: pixel clock, line and frame sync, byte data.
 * Assumes the bench calls idle and send; pins are async to aclk.
 */
`timescale 1ns/1ns
`default_nettype none

module cicc_sensor_model (
    output logic       pclk_pin,
    output logic       line_sync_pin,
    output logic       frame_sync_pin,
    output logic [7:0] data_pin
);
    // quiet levels before the first frame
    initial begin
        pclk_pin       = 1'b0;
        line_sync_pin  = 1'b0;
        frame_sync_pin = 1'b0;
        data_pin       = 8'h5a;
    end

    // park the link between frames; pclk stands still
    task automatic idle(input logic fi, input logic li, input logic park);
        frame_sync_pin = fi;
        line_sync_pin  = li;
        pclk_pin       = park;
        data_pin       = ~data_pin; // released data, never the last value
    endtask

    // one frame at 125 ns per byte, first byte in s[7:0]
    task automatic send(input logic [95:0] s, input int n,
                        input logic fa, input logic la);
        #3;
        frame_sync_pin = fa;
        line_sync_pin  = la;
        #100;
        for (int i = 0; i < n; i++) begin
            data_pin = s[8*i +: 8];
            #62 pclk_pin = ~pclk_pin; // sampling edge
            #63 pclk_pin = ~pclk_pin;
        end
        #20 data_pin = ~data_pin; // hold time over
        #100;
        line_sync_pin  = ~la;
        frame_sync_pin = ~fa;
    endtask

endmodule // cicc_sensor_model

`default_nettype wire

// >>> verification/camera_input_capture_config_test.sv
/*
 * Self-checking bench of the capture configuration block: register
 * access over AXI4-Lite and sensor frames through the partner model.
 * Assumes the constants header and the sensor model are compiled too.
 */
`timescale 1ns/1ns
`default_nettype none
`include "cicc_consts.svh"

module camera_input_capture_config_test;
    logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0;
    logic        wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic        rready = 1'b0;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, pixel_word, last_word, got_data;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        pclk_pin, line_sync_pin, frame_sync_pin;
    logic        pixel_word_valid, frame_start, dma_burst_reserved;
    logic [1:0]  bresp, rresp, got_resp;
    logic [7:0]  data_pin;
    logic [2:0]  dma_hburst;
    int          fails, n_compared, n_words, n_fs;
    logic [2:0]  hb [4] = '{`CICC_HBURST_INCR4, `CICC_HBURST_INCR8,
                           `CICC_HBURST_INCR16, `CICC_HBURST_INCR4};
    localparam logic [95:0] PLAIN = 96'h4433_2211;
    localparam logic [95:0] PAD6  = 96'h6655_4433_2211;
    localparam logic [95:0] EMB   = 96'hb00000ff_44332211_800000ff;
    localparam logic [31:0] WORD  = 32'h4433_2211;

    // 100 MHz clock
    always #5 aclk = ~aclk;

    cicc_top dut_u (
        .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
        .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arprot(3'h0), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .pclk_pin(pclk_pin), .line_sync_pin(line_sync_pin),
        .frame_sync_pin(frame_sync_pin), .data_pin(data_pin),
        .pixel_word(pixel_word), .pixel_word_valid(pixel_word_valid),
        .frame_start(frame_start), .dma_hburst(dma_hburst),
        .dma_burst_reserved(dma_burst_reserved));

    cicc_sensor_model sensor_u (
        .pclk_pin(pclk_pin), .line_sync_pin(line_sync_pin),
        .frame_sync_pin(frame_sync_pin), .data_pin(data_pin));

    // count packed words and frame starts
    always @(posedge aclk) begin
        if (pixel_word_valid === 1'b1) begin
            n_words++;
            last_word = pixel_word;
        end
        if (frame_start === 1'b1)
            n_fs++;
    end

    // compare and report
    task automatic check(input string what, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // verdict and end of run
    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // wait for the rising edge that completes the handshake and take the
    // answer there; only the watchdog ends a hang
    task automatic hs(input int k);
        bit ok = 1'b0;
        while (!ok) begin
            @(posedge aclk);
            case (k)
                0: ok = awready & wready;
                1: ok = bvalid;
                2: ok = arready;
                default: ok = rvalid;
            endcase
            got_resp = (k == 1) ? bresp : rresp;
            got_data = rdata;
        end
    endtask

    // register write; address and data offered together
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                          input logic [3:0] s);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        hs(0);
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        hs(1);
        bready  <= 1'b0;
        @(posedge aclk);
    endtask

    // register read
    task automatic axi_rd(input logic [3:0] a);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        hs(2);
        arvalid <= 1'b0;
        hs(3);
        rready  <= 1'b0;
        @(posedge aclk);
    endtask

    // capture configuration word from its fields
    function automatic logic [31:0] mk(input logic fp, lp, ed, pd, sr,
                                       input logic [1:0] md);
        mk = 32'h0;
        mk[`CICC_FS_POL_BIT] = fp;
        mk[`CICC_LS_POL_BIT] = lp;
        mk[`CICC_EDGE_BIT]   = ed;
        mk[`CICC_BURST_LO]   = 1'b1;
        mk[`CICC_PAD_BIT]    = pd;
        mk[`CICC_FS_SRC_BIT] = sr;
        mk[1:0]              = md;
    endfunction

    // configure, send one frame, check words and frame starts
    task automatic run(input logic [31:0] c, input logic [95:0] s,
                       input int n, input logic fa, la,
                       input int en, input logic [31:0] ew);
        sensor_u.idle(~fa, ~la, c[`CICC_EDGE_BIT]);
        axi_wr(`CICC_ADDR_CONFIG, c, 4'hf);
        repeat (10) @(posedge aclk);
        n_words = 0;
        n_fs = 0;
        sensor_u.send(s, n, fa, la);
        repeat (20) @(posedge aclk);
        check("word count", n_words, en);
        if (en > 0) begin
            check("last word", last_word, ew);
            check("frame starts", n_fs, 1);
        end
        $display("frame test done, config %h", c);
    endtask

    // main sequence
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_rd(`CICC_ADDR_CONFIG);
        check("config reset", got_data, `CICC_CFG_RESET);
        axi_wr(`CICC_ADDR_CONFIG, 32'hffff_ffff, 4'h1);
        axi_rd(`CICC_ADDR_CONFIG);
        check("low lane", got_data, 32'h0000_0003);
        axi_wr(`CICC_ADDR_CONFIG, 32'hffff_ffff, 4'hf);
        axi_rd(`CICC_ADDR_CONFIG);
        check("all lanes", got_data, 32'h0000_7f03);
        axi_rd(4'h8);
        check("unmapped read", got_resp, `CICC_RESP_SLVERR);
        axi_wr(4'hc, 32'h1, 4'hf);
        check("unmapped write", got_resp, `CICC_RESP_SLVERR);
        $display("register test done");
        for (int k = 0; k < 4; k++) begin
            axi_wr(`CICC_ADDR_CONFIG, {20'h0, k[1:0], 10'h0}, 4'hf);
            check("burst", dma_hburst, hb[k]);
            check("burst reserved", dma_burst_reserved, k == 3);
        end
        $display("burst test done");
        run(mk(0,0,0,0,0,2), PLAIN, 4, 1, 1, 1, WORD);
        run(mk(1,1,1,0,0,2), PLAIN, 4, 0, 0, 1, WORD);
        run(mk(0,0,0,1,0,2), PAD6, 6, 1, 1, 2, 32'h0066_5544);
        run(mk(0,1,0,0,0,2), PLAIN, 4, 1, 1, 0, 32'h0);
        run(mk(0,0,0,0,1,1), EMB, 12, 0, 1, 1, WORD);
        run(mk(1,0,0,0,0,0), EMB, 12, 1, 1, 1, WORD);
        run(mk(0,0,0,0,1,0), EMB, 12, 0, 1, 0, 32'h0);
        give_verdict();
    end

    // watchdog: the tests need well under 50 us
    initial begin
        #200000;
        fails++;
        give_verdict();
    end

endmodule // camera_input_capture_config_test

`default_nettype wire
